/* core/lbus_device.sv */
/*
 holds the device end: decodes host cycles, claims, answers with ready.
 assumes the host keeps its strobe, select and byte enable duties.
*/
// Functional notes
// - 32-bit shared data, device drives reads
// - word address bits are inputs only
// - io decode uses address bits 15:2
// - host marks valid byte lanes active low
// - select low io, high memory
// - direction low read, high write
// - strobe low starts cycle
// - all control timed to link clock; reset and interrupt here act on any ref clock
// - ready return low holds read data
// - claim low for owned resource
// - ready low ends claimed cycle, open-collector
// - reset high holds idle, ignores cycles
// - interrupt low while condition pending
`timescale 1ns/1ps
module lbus_device
    import lbus_pkg::*;
#(
    parameter int MEM_N = MEM_WORDS,
    parameter int IO_N = IO_WORDS
) (
    // system
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // link
    lbus_if.dev bus,
    // user side
    input wire logic irq_req_in,
    output logic irq_pending_out,
    output logic [31:0] last_write_out
);
    localparam int LANE_W = DATA_W / LANES;
    typedef enum {ST_IDLE, ST_DECODE, ST_ANSWER, ST_HOLD} state_type;
    state_type state;
    logic [SYNC_W-1:0] clk_s, ads_s, rtn_s, rst_s;
    logic [SYNC_W-1:0] wnr_s, mio_s;
    logic [ADDR_HI:ADDR_LO] addr_s [SYNC_W];
    logic [3:0] be_s [SYNC_W];
    logic [31:0] data_s [SYNC_W];
    logic clk_d;
    logic rise;
    logic [31:0] mem [MEM_N];
    logic [31:0] regs [IO_N];
    // captured cycle
    logic [ADDR_HI:ADDR_LO] cyc_addr;
    logic cyc_write;
    logic cyc_mem;
    logic [3:0] cyc_be_n;
    logic hit;
    logic [31:0] rdata;
    logic [31:0] wdata;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] be_n);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < LANES; i++) begin
            if (!be_n[i]) begin
                r[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction

    // pin synchronisers
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clk_s <= '0;
            ads_s <= '1;
            rtn_s <= '1;
            rst_s <= '1;
            clk_d <= 1'b0;
            wnr_s <= '0;
            mio_s <= '1;
            addr_s <= '{default: '0};
            be_s <= '{default: '1};
            data_s <= '{default: DATA_RST};
        end else begin
            clk_s <= {clk_s[0], bus.host_bus_clk};
            wnr_s <= {wnr_s[0], bus.write_not_read};
            mio_s <= {mio_s[0], bus.mem_or_io_sel};
            addr_s <= '{bus.addr, addr_s[0]};
            be_s <= '{bus.byte_lane_en_n, be_s[0]};
            data_s <= '{bus.data, data_s[0]};
            ads_s <= {ads_s[0], bus.addr_strobe_n};
            rtn_s <= {rtn_s[0], bus.ready_return_n};
            rst_s <= {rst_s[0], bus.reset};
            clk_d <= clk_s[1];
        end
    end
    assign rise = clk_s[1] && !clk_d;

    // window decode
    always_comb begin
        if (cyc_mem) begin
            hit = (cyc_addr & MEM_MASK) == MEM_BASE;
        end else begin
            hit = (cyc_addr[IO_HI:ADDR_LO] & IO_MASK) == IO_BASE;
        end
    end

    // read word select
    always_comb begin
        if (cyc_mem) begin
            rdata = mem[cyc_addr[ADDR_LO +: $clog2(MEM_N)]];
        end else begin
            rdata = regs[cyc_addr[ADDR_LO +: $clog2(IO_N)]];
        end
    end

    // merged write word
    always_comb begin
        wdata = merge(rdata, data_s[1], cyc_be_n);
    end

    // cycle sequencer
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
            cyc_addr <= '0;
            cyc_write <= 1'b0;
            cyc_mem <= 1'b0;
            cyc_be_n <= '1;
            bus.bus_claim_n <= 1'b1;
            bus.ready_oe_n <= 1'b1;
            bus.ready_drv <= 1'b0;
            bus.dev_data_oe_n <= 1'b1;
            bus.dev_data <= DATA_RST;
            last_write_out <= DATA_RST;
            for (int i = 0; i < MEM_N; i++) begin
                mem[i] <= DATA_RST;
            end
            for (int i = 0; i < IO_N; i++) begin
                regs[i] <= DATA_RST;
            end
        end else if (rst_s[1]) begin
            state <= ST_IDLE;
            bus.bus_claim_n <= 1'b1;
            bus.ready_oe_n <= 1'b1;
            bus.ready_drv <= 1'b0;
            bus.dev_data_oe_n <= 1'b1;
        end else if (rise) begin
            unique case (state)
                ST_IDLE: begin
                    if (!ads_s[1]) begin
                        cyc_addr <= addr_s[1];
                        cyc_write <= wnr_s[1];
                        cyc_mem <= mio_s[1];
                        cyc_be_n <= be_s[1];
                        state <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    if (hit) begin
                        bus.bus_claim_n <= 1'b0;
                        if (cyc_write) begin
                            if (cyc_mem) begin
                                mem[cyc_addr[ADDR_LO +: $clog2(MEM_N)]] <= wdata;
                            end else begin
                                regs[cyc_addr[ADDR_LO +: $clog2(IO_N)]] <= wdata;
                            end
                            last_write_out <= wdata;
                        end else begin
                            bus.dev_data <= rdata;
                            bus.dev_data_oe_n <= 1'b0;
                        end
                        bus.ready_drv <= 1'b0;
                        bus.ready_oe_n <= 1'b0;
                        state <= ST_ANSWER;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_ANSWER: begin
                    bus.ready_oe_n <= 1'b1;
                    bus.bus_claim_n <= 1'b1;
                    if (!cyc_write && !rtn_s[1]) begin
                        state <= ST_HOLD;
                    end else begin
                        bus.dev_data_oe_n <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    if (rtn_s[1]) begin
                        bus.dev_data_oe_n <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // interrupt request
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus.irq_n <= 1'b1;
            irq_pending_out <= 1'b0;
        end else begin
            bus.irq_n <= !(irq_req_in && !rst_s[1]);
            irq_pending_out <= irq_req_in && !rst_s[1];
        end
    end
endmodule

/* pkg/lbus_pkg.sv */
/*
 holds shared constants and types for the local bus host port pair.
 assumes both ends and the interface import it.
*/
package lbus_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_HI = 31;
    localparam int ADDR_LO = 2;
    localparam int IO_HI = 15;
    localparam int LANES = 4;
    // device decode windows, memory on word address bits [31:2], io on [15:2]
    localparam logic [29:0] MEM_BASE = 30'h0200_0000;
    localparam logic [29:0] MEM_MASK = 30'h3F00_0000;
    localparam logic [13:0] IO_BASE = 14'h00F0;
    localparam logic [13:0] IO_MASK = 14'h3FF0;
    localparam int MEM_WORDS = 16;
    localparam int IO_WORDS = 16;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    // link clock divider half period in ref clocks (40 ns at 5 ns)
    localparam int LINK_HALF = 8;
    localparam int SYNC_W = 2;
    typedef enum logic {CYC_IO, CYC_MEM} cyc_kind_type;
endpackage

/* pkg/lbus_if.sv */
/*
 holds the local bus interface joining the host end and device end.
 resolves the shared data and ready wires from the enables itself.
*/
`timescale 1ns/1ps
interface lbus_if;
    import lbus_pkg::*;
    logic host_bus_clk;
    logic addr_strobe_n;
    logic mem_or_io_sel;
    logic write_not_read;
    logic [3:0] byte_lane_en_n;
    logic [ADDR_HI:ADDR_LO] addr;
    logic ready_return_n;
    logic [31:0] host_data;
    logic host_data_oe_n;
    logic [31:0] dev_data;
    logic dev_data_oe_n;
    logic [31:0] data;
    logic bus_claim_n;
    logic ready_drv;
    logic ready_oe_n;
    logic ready_n;
    logic reset;
    logic irq_n;
    // released data lines float to their pull-up level
    assign data = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : '1);
    assign ready_n = ready_oe_n ? 1'b1 : ready_drv;
    modport host (output host_bus_clk, addr_strobe_n, mem_or_io_sel, write_not_read,
        byte_lane_en_n, addr, ready_return_n, host_data, host_data_oe_n, reset,
        input data, bus_claim_n, ready_n, irq_n);
    modport dev (input host_bus_clk, addr_strobe_n, mem_or_io_sel, write_not_read,
        byte_lane_en_n, addr, ready_return_n, data, reset, ready_n,
        output dev_data, dev_data_oe_n, bus_claim_n, ready_drv, ready_oe_n, irq_n);
endinterface

/* core/lbus_host.sv */
/*
 holds the host end: makes the link clock and runs single bus cycles.
 assumes the device answers each claimed cycle with one ready.
*/
`timescale 1ns/1ps
module lbus_host
    import lbus_pkg::*;
#(
    parameter int HALF = LINK_HALF,
    parameter int TIMEOUT = 16
) (
    // system
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // link
    lbus_if.host bus,
    // user side
    input wire logic req_in,
    input wire logic req_write_in,
    input wire logic req_mem_in,
    input wire logic [29:0] req_addr_in,
    input wire logic [3:0] req_be_n_in,
    input wire logic [31:0] req_data_in,
    input wire logic hold_read_in,
    input wire logic dev_reset_in,
    output logic busy_out,
    output logic done_out,
    output logic claimed_out,
    output logic [31:0] rdata_out,
    output logic irq_out
);
    typedef enum {ST_IDLE, ST_ADDR, ST_WAIT, ST_HOLD} state_type;
    state_type state;
    logic [$clog2(HALF+1)-1:0] div;
    logic rise_next;
    logic [SYNC_W-1:0] rdy_s, clm_s, irq_s;
    logic [31:0] data_s [SYNC_W];
    logic [$clog2(TIMEOUT+1)-1:0] wait_cnt;

    // link clock divider
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div <= '0;
            bus.host_bus_clk <= 1'b0;
        end else if (div == ($clog2(HALF+1))'(HALF-1)) begin
            div <= '0;
            bus.host_bus_clk <= !bus.host_bus_clk;
        end else begin
            div <= div + 1'b1;
        end
    end
    assign rise_next = (div == ($clog2(HALF+1))'(HALF-1)) && !bus.host_bus_clk;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdy_s <= '1;
            clm_s <= '1;
            irq_s <= '1;
            data_s <= '{default: DATA_RST};
            irq_out <= 1'b0;
            bus.reset <= 1'b1;
        end else begin
            rdy_s <= {rdy_s[0], bus.ready_n};
            clm_s <= {clm_s[0], bus.bus_claim_n};
            irq_s <= {irq_s[0], bus.irq_n};
            data_s <= '{bus.data, data_s[0]};
            irq_out <= !irq_s[1];
            bus.reset <= dev_reset_in;
        end
    end

    // cycle sequencer, changes only at link clock rise except the one ref clock done_out pulse
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
            bus.addr_strobe_n <= 1'b1;
            bus.mem_or_io_sel <= 1'b1;
            bus.write_not_read <= 1'b0;
            bus.byte_lane_en_n <= '1;
            bus.addr <= '0;
            bus.ready_return_n <= 1'b1;
            bus.host_data <= DATA_RST;
            bus.host_data_oe_n <= 1'b1;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            claimed_out <= 1'b0;
            rdata_out <= DATA_RST;
            wait_cnt <= '0;
        end else begin
            done_out <= 1'b0;
            if (rise_next) begin
                unique case (state)
                    ST_IDLE: begin
                        if (req_in) begin
                            bus.addr_strobe_n <= 1'b0;
                            bus.mem_or_io_sel <= req_mem_in;
                            bus.write_not_read <= req_write_in;
                            bus.byte_lane_en_n <= req_be_n_in;
                            bus.addr <= req_addr_in;
                            bus.host_data <= req_data_in;
                            bus.host_data_oe_n <= !req_write_in;
                            busy_out <= 1'b1;
                            claimed_out <= 1'b0;
                            wait_cnt <= '0;
                            state <= ST_ADDR;
                        end
                    end
                    ST_ADDR: begin
                        bus.addr_strobe_n <= 1'b1;
                        state <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (!clm_s[1]) begin
                            claimed_out <= 1'b1;
                        end
                        if (!rdy_s[1]) begin
                            rdata_out <= data_s[1];
                            bus.host_data_oe_n <= 1'b1;
                            if (!bus.write_not_read && hold_read_in) begin
                                bus.ready_return_n <= 1'b0;
                                state <= ST_HOLD;
                            end else begin
                                busy_out <= 1'b0;
                                done_out <= 1'b1;
                                state <= ST_IDLE;
                            end
                        end else if (wait_cnt == ($clog2(TIMEOUT+1))'(TIMEOUT)) begin
                            bus.host_data_oe_n <= 1'b1;
                            busy_out <= 1'b0;
                            done_out <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            wait_cnt <= wait_cnt + 1'b1;
                        end
                    end
                    ST_HOLD: begin
                        bus.ready_return_n <= 1'b1;
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* bench/lbus_checker.sv */
/*
 holds concurrent checks on the link between host end and device end.
 assumes the bench wires the interface signals in by name.
*/
`timescale 1ns/1ps
module lbus_checker
    import lbus_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // host driven
    input wire logic addr_strobe_n,
    input wire logic mem_or_io_sel,
    input wire logic write_not_read,
    input wire logic [ADDR_HI:ADDR_LO] addr,
    input wire logic ready_return_n,
    input wire logic host_data_oe_n,
    input wire logic reset,
    // device driven
    input wire logic [31:0] dev_data,
    input wire logic dev_data_oe_n,
    input wire logic bus_claim_n,
    input wire logic ready_n,
    input wire logic irq_n
);
    logic cap_mem, cap_wr;
    logic [29:0] cap_addr;
    int since, rdy_cnt;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // cycle status captured at strobe, age and ready count per cycle
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cap_mem <= 1'b0;
            cap_wr <= 1'b0;
            cap_addr <= '0;
            since <= 0;
            rdy_cnt <= 0;
        end else if (!addr_strobe_n) begin
            cap_mem <= mem_or_io_sel;
            cap_wr <= write_not_read;
            cap_addr <= addr;
            since <= 0;
            rdy_cnt <= 0;
        end else begin
            if (since < 1000) since <= since + 1;
            if ($fell(ready_n) && rdy_cnt < 3) rdy_cnt <= rdy_cnt + 1;
        end
    end
    property p_claim_hit;
        $fell(bus_claim_n) |-> (cap_mem ? ((cap_addr & MEM_MASK) == MEM_BASE)
            : ((cap_addr[13:0] & IO_MASK) == IO_BASE));
    endproperty
    a_claim_hit: assert property (p_claim_hit) else $error("claim outside window");
    property p_claim_soon;
        $fell(bus_claim_n) |-> since < 80;
    endproperty
    a_claim_soon: assert property (p_claim_soon) else $error("claim late");
    property p_ready_claim;
        !ready_n |-> !bus_claim_n;
    endproperty
    a_ready_claim: assert property (p_ready_claim) else $error("ready without claim");
    property p_ready_len;
        $fell(ready_n) |-> (!ready_n)[*8] ##[1:16] ready_n;
    endproperty
    a_ready_len: assert property (p_ready_len) else $error("ready width wrong");
    property p_one_ready;
        rdy_cnt <= 1;
    endproperty
    a_one_ready: assert property (p_one_ready) else $error("extra ready");
    property p_read_dir;
        !dev_data_oe_n |-> !cap_wr;
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("device drives on write");
    property p_no_fight;
        !dev_data_oe_n |-> host_data_oe_n;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("data contention");
    property p_host_write;
        !host_data_oe_n |-> write_not_read;
    endproperty
    a_host_write: assert property (p_host_write) else $error("host drives on read");
    property p_hold_data;
        (!ready_return_n)[*4] ##0 !dev_data_oe_n |=> !dev_data_oe_n && $stable(dev_data);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("read data dropped");
    property p_reset_idle;
        reset[*6] |-> bus_claim_n && ready_n && dev_data_oe_n && irq_n;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("active in reset");
endmodule

/* bench/tb.sv */
/*
 holds the self-checking bench joining host end and device end.
 assumes the design package and interface are compiled first.
*/
`timescale 1ns/1ps
module tb;
    import lbus_pkg::*;
    logic ref_clk_in, nrst_in, req_in, req_write_in, req_mem_in, hold_read_in;
    logic dev_reset_in, irq_req_in, busy_out, done_out, claimed_out, irq_out, irq_pending_out;
    logic [29:0] req_addr_in;
    logic [3:0] req_be_n_in;
    logic [31:0] req_data_in, rdata_out, last_write_out, last_wr;
    logic [31:0] mem_m [16];
    logic [31:0] io_m [16];
    logic have_wr;
    int err_total, num_checks;
    lbus_if link();
    lbus_host #(.HALF(LINK_HALF), .TIMEOUT(4)) lbus_host_inst (.ref_clk_in, .nrst_in,
        .bus(link), .req_in, .req_write_in, .req_mem_in, .req_addr_in, .req_be_n_in,
        .req_data_in, .hold_read_in, .dev_reset_in, .busy_out, .done_out, .claimed_out,
        .rdata_out, .irq_out);
    lbus_device lbus_device_inst (.ref_clk_in, .nrst_in, .bus(link), .irq_req_in,
        .irq_pending_out, .last_write_out);
    lbus_checker lbus_checker_inst (.ref_clk_in, .nrst_in, .addr_strobe_n(link.addr_strobe_n),
        .mem_or_io_sel(link.mem_or_io_sel), .write_not_read(link.write_not_read),
        .addr(link.addr), .ready_return_n(link.ready_return_n),
        .host_data_oe_n(link.host_data_oe_n), .reset(link.reset), .dev_data(link.dev_data),
        .dev_data_oe_n(link.dev_data_oe_n), .bus_claim_n(link.bus_claim_n),
        .ready_n(link.ready_n), .irq_n(link.irq_n));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
        input logic [3:0] be_n);
        for (int i = 0; i < 4; i++) if (!be_n[i]) o[i*8 +: 8] = n[i*8 +: 8];
        return o;
    endfunction
    function automatic logic hit(input logic mem, input logic [29:0] a);
        if (mem) return (a & MEM_MASK) == MEM_BASE;
        return (a[13:0] & IO_MASK) == IO_BASE;
    endfunction
    task automatic run(input logic wr, input logic mem, input logic [29:0] a,
        input logic [3:0] be_n, input logic [31:0] d, input logic hold, input logic live);
        int n;
        logic h;
        logic [31:0] e;
        h = live && hit(mem, a);
        e = mem ? mem_m[a[3:0]] : io_m[a[3:0]];
        @(negedge ref_clk_in);
        {req_write_in, req_mem_in, req_addr_in, req_be_n_in} = {wr, mem, a, be_n};
        {req_data_in, hold_read_in, req_in} = {d, hold, 1'b1};
        n = 0;
        while (busy_out !== 1'b1 && n < 300) begin
            @(negedge ref_clk_in);
            n++;
        end
        req_in = 1'b0;
        while (done_out !== 1'b1 && n < 900) begin
            @(negedge ref_clk_in);
            n++;
        end
        cmp({31'h0, done_out}, 32'h1);
        cmp({31'h0, claimed_out}, {31'h0, h});
        if (h && wr) begin
            e = merge(e, d, be_n);
            if (mem) mem_m[a[3:0]] = e;
            else io_m[a[3:0]] = e;
            last_wr = e;
            have_wr = 1'b1;
        end
        if (h && !wr) cmp(rdata_out, e);
        if (have_wr) cmp(last_write_out, last_wr);
        @(negedge ref_clk_in);
    endtask
    function automatic logic [29:0] mk(input logic mem, input logic [3:0] i,
        input logic miss);
        if (mem) return (MEM_BASE | 30'(i)) ^ (miss ? 30'h0100_0000 : 30'h0);
        return {16'($urandom), (IO_BASE | 14'(i)) ^ (miss ? 14'h0100 : 14'h0)};
    endfunction
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #150000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        logic m, w;
        static logic [3:0] lanes [7] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'h5, 4'hA};
        {nrst_in, req_in, req_write_in, req_mem_in, hold_read_in} = 5'b0;
        {dev_reset_in, irq_req_in, req_addr_in, req_be_n_in, req_data_in} = '0;
        dev_reset_in = 1'b1;
        irq_req_in = 1'b1;
        have_wr = 1'b0;
        void'($urandom(32'h0000_fb35));
        repeat (8) @(negedge ref_clk_in);
        nrst_in = 1'b1;
        run(1'b1, 1'b1, MEM_BASE, 4'h0, 32'h1234_5678, 1'b0, 1'b0);
        cmp({30'h0, irq_out, irq_pending_out}, 32'h0);
        dev_reset_in = 1'b0;
        repeat (64) @(negedge ref_clk_in);
        cmp({30'h0, irq_out, irq_pending_out}, 32'h3);
        irq_req_in = 1'b0;
        repeat (64) @(negedge ref_clk_in);
        cmp({30'h0, irq_out, irq_pending_out}, 32'h0);
        $display("test reset_irq done");
        for (int i = 0; i < 16; i++) begin
            run(1'b1, 1'b1, mk(1'b1, 4'(i), 1'b0), 4'h0, $urandom, 1'b0, 1'b1);
            run(1'b1, 1'b0, mk(1'b0, 4'(i), 1'b0), 4'h0, $urandom, 1'b0, 1'b1);
        end
        $display("test fill done");
        foreach (lanes[k]) begin
            run(1'b1, k[0], mk(k[0], 4'd3, 1'b0), lanes[k], $urandom, 1'b0, 1'b1);
            run(1'b0, k[0], mk(k[0], 4'd3, 1'b0), 4'h0, 32'h0, 1'b1, 1'b1);
        end
        $display("test lanes done");
        for (int k = 0; k < 4; k++) begin
            run(k[0], k[1], mk(k[1], 4'd5, 1'b1), 4'h0, $urandom, 1'b0, 1'b1);
        end
        $display("test miss done");
        repeat (30) begin
            m = 1'($urandom);
            w = 1'($urandom);
            run(w, m, mk(m, 4'($urandom), ($urandom % 4) == 0), 4'($urandom), $urandom,
                1'($urandom), 1'b1);
        end
        $display("test random done");
        tally_and_finish();
    end
endmodule
